// ---- verilog/bst_tap.sv ----
`timescale 1ns/1ps
`include "bst_defines.svh"
// Notes on behaviour
// - mode select sampled on rising scan clock
// - sixteen state controller, moves on rising edge
// - power-up or five ones enter reset
// - data in accepted only in shift states
// - data out driven only in shift states
// - capture on rise, shift out on fall
// - three-bit instruction, preset to identify code
// - new instruction acts only at update
// - codes 000,010,100 capture and shift ring
// - code 000 drives outputs from cells
// - codes 000,010 switch off input termination
// - code 010 floats read-data drivers
// - code 001 captures and shifts identity
// - other codes leave memory undisturbed
// - code 111 one-bit bypass loads zero
// - identity 32 bits, bit0 one, lsb out
// - cell 128 gates read drivers, captures one
module bst_tap
  import bst_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h1234_5001, // arbitrary identity
  parameter int          RING_W   = `BST_CHAIN_LEN
)(
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  input  wire logic              TCK,
  input  wire logic              TMS,
  input  wire logic              TDI,
  output logic                   TDO,
  output logic                   TDO_OE_N,
  input  wire logic [RING_W-1:0] RING_IN,
  input  wire logic [`BST_OUT_CELLS-1:0] CORE_OUT,
  output logic [`BST_OUT_CELLS-1:0] PIN_OUT,
  output logic                   READ_DATA_EN,
  output logic                   INPUT_TERMINATION,
  output logic                   TEST_MODE
);
  // cells 0..3 are read data, read_valid_out, echo_clock_out pair
  // refuse at elaboration a ring the cell map cannot serve, or no start bit
  if (RING_W != `BST_CHAIN_LEN || ID_VALUE[0] != 1'b1)
  begin : g_bad_param
    $error("bst_tap: unsupported ring width or identity");
  end

  // two-flop sync of the scan pins; stage one read only by stage two
  bst_pins_t sync1, sync2, prev;
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end
    else
    begin
      sync1 <= '{TCK, TMS, TDI};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end
  logic rise, fall;
  assign rise = sync2.tck & ~prev.tck;
  assign fall = ~sync2.tck & prev.tck;

  // controller next state, standard graph
  bst_state_t state, next_state;
  always_comb
  begin
    next_state = state;
    if (rise)
    begin
      unique case (state)
        BST_RESET:    next_state = sync2.tms ? BST_RESET : BST_IDLE;
        BST_IDLE:     next_state = sync2.tms ? BST_SEL_DR : BST_IDLE;
        BST_SEL_DR:   next_state = sync2.tms ? BST_SEL_IR : BST_CAP_DR;
        BST_CAP_DR:   next_state = sync2.tms ? BST_EXIT1_DR : BST_SHIFT_DR;
        BST_SHIFT_DR: next_state = sync2.tms ? BST_EXIT1_DR : BST_SHIFT_DR;
        BST_EXIT1_DR: next_state = sync2.tms ? BST_UPD_DR : BST_PAUSE_DR;
        BST_PAUSE_DR: next_state = sync2.tms ? BST_EXIT2_DR : BST_PAUSE_DR;
        BST_EXIT2_DR: next_state = sync2.tms ? BST_UPD_DR : BST_SHIFT_DR;
        BST_UPD_DR:   next_state = sync2.tms ? BST_SEL_DR : BST_IDLE;
        BST_SEL_IR:   next_state = sync2.tms ? BST_RESET : BST_CAP_IR;
        BST_CAP_IR:   next_state = sync2.tms ? BST_EXIT1_IR : BST_SHIFT_IR;
        BST_SHIFT_IR: next_state = sync2.tms ? BST_EXIT1_IR : BST_SHIFT_IR;
        BST_EXIT1_IR: next_state = sync2.tms ? BST_UPD_IR : BST_PAUSE_IR;
        BST_PAUSE_IR: next_state = sync2.tms ? BST_EXIT2_IR : BST_PAUSE_IR;
        BST_EXIT2_IR: next_state = sync2.tms ? BST_UPD_IR : BST_SHIFT_IR;
        BST_UPD_IR:   next_state = sync2.tms ? BST_SEL_DR : BST_IDLE;
      endcase
    end
  end

  // scan registers: capture/shift on rise, update at update states
  logic [`BST_IR_W-1:0] ir_shift, next_ir_shift;
  logic [`BST_IR_W-1:0] instr, next_instr;
  logic                 bypass, next_bypass;
  logic [`BST_ID_W-1:0] id_shift, next_id_shift;
  logic [RING_W-1:0]    ring, next_ring;
  logic [`BST_OUT_CELLS:0] upd, next_upd; // update latches incl gate cell
  logic                 out_bit, next_out_bit;
  logic                 sel_ring, is_drive, is_float;

  assign is_drive = (instr == `BST_OP_DRIVE);
  assign is_float = (instr == `BST_OP_FLOAT);
  assign sel_ring = is_drive | is_float | (instr == `BST_OP_SAMPLE);

  always_comb
  begin
    next_ir_shift = ir_shift;
    next_instr    = instr;
    next_bypass   = bypass;
    next_id_shift = id_shift;
    next_ring     = ring;
    next_upd      = upd;
    next_out_bit  = out_bit;
    if (rise)
    begin
      unique case (state)
        BST_RESET:    next_instr = `BST_IR_RESET;
        BST_CAP_IR:   next_ir_shift = `BST_IR_RESET;
        BST_SHIFT_IR: next_ir_shift = {sync2.tdi, ir_shift[2:1]};
        BST_UPD_IR:   next_instr = ir_shift;
        BST_CAP_DR:
        begin
          next_bypass   = 1'b0;
          next_id_shift = ID_VALUE;
          next_ring     = RING_IN;
          next_ring[`BST_GATE_CELL] = `BST_GATE_RESET;
        end
        BST_SHIFT_DR:
        begin
          // data enters at msb, leaves from lsb
          if (instr == `BST_OP_BYPASS)
            next_bypass = sync2.tdi;
          else if (instr == `BST_OP_IDENT)
            next_id_shift = {sync2.tdi, id_shift[`BST_ID_W-1:1]};
          else if (sel_ring)
            next_ring = {sync2.tdi, ring[RING_W-1:1]};
          else
            next_bypass = sync2.tdi; // reserved codes act as bypass
        end
        BST_UPD_DR:
          if (is_drive)
            next_upd = {ring[`BST_GATE_CELL], ring[`BST_OUT_CELLS-1:0]};
        default: ;
      endcase
    end
    if (fall) // output bit changes only on falling edge
    begin
      if (state == BST_SHIFT_IR)
        next_out_bit = ir_shift[0];
      else if (instr == `BST_OP_IDENT)
        next_out_bit = id_shift[0];
      else if (sel_ring)
        next_out_bit = ring[0];
      else
        next_out_bit = bypass;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state    <= BST_RESET;
      ir_shift <= `BST_IR_RESET;
      instr    <= `BST_IR_RESET;
      bypass   <= 1'b0;
      id_shift <= '0;
      ring     <= '0;
      upd      <= '0;
      out_bit  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      ir_shift <= next_ir_shift;
      instr    <= next_instr;
      bypass   <= next_bypass;
      id_shift <= next_id_shift;
      ring     <= next_ring;
      upd      <= next_upd;
      out_bit  <= next_out_bit;
    end
  end

  // five ones from any state reach reset; counter only feeds an assertion
  logic [2:0] ones;
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      ones <= 3'h0;
    else if (rise)
      ones <= sync2.tms ? ((ones == 3'h5) ? ones : ones + 3'h1) : 3'h0;
  end

  // pin side: test mode gating of functional outputs
  logic shift_st;
  assign shift_st = (state == BST_SHIFT_IR) || (state == BST_SHIFT_DR);
  assign TDO      = out_bit;
  assign TDO_OE_N = ~shift_st; // low while driving
  assign TEST_MODE         = is_drive | is_float;
  assign INPUT_TERMINATION = ~(is_drive | is_float);
  assign PIN_OUT      = is_drive ? upd[`BST_OUT_CELLS-1:0] : CORE_OUT;
  assign READ_DATA_EN = is_float ? 1'b0
                      : is_drive ? upd[`BST_OUT_CELLS] : 1'b1;

  a_five_ones_reset: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    (ones == 3'h5) |-> (state == BST_RESET))
    else $error("five ones did not reach reset");
  a_tdo_enable: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    TDO_OE_N == !(state inside {BST_SHIFT_IR, BST_SHIFT_DR}))
    else $error("tdo enable outside shift");
  a_tdo_enter: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $fell(TDO_OE_N) |-> $past(state) inside {BST_CAP_IR, BST_EXIT2_IR,
      BST_CAP_DR, BST_EXIT2_DR})
    else $error("tdo enabled without entering shift");
  a_ir_update: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $changed(instr) |-> $past(state) inside {BST_UPD_IR, BST_RESET})
    else $error("instruction changed outside update");
  a_ir_capture: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    (rise && state == BST_CAP_IR) |=> ir_shift == `BST_IR_RESET)
    else $error("instruction capture not 001");
  a_bypass_zero: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    (rise && state == BST_CAP_DR) |=> !bypass)
    else $error("bypass capture not zero");
  a_tdo_on_fall: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $changed(TDO) |-> $past(fall))
    else $error("tdo moved off falling edge");
  a_float_drivers: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    is_float |-> !READ_DATA_EN && !INPUT_TERMINATION)
    else $error("float code left drivers on");
  a_state_on_rise: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    $changed(state) |-> $past(rise))
    else $error("state moved without rising edge");
  a_gate_capture: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    (rise && state == BST_CAP_DR) |=> ring[`BST_GATE_CELL])
    else $error("gate cell did not capture one");
  a_idle_normal: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    (instr == `BST_OP_BYPASS) |-> PIN_OUT == CORE_OUT && READ_DATA_EN)
    else $error("bypass disturbed memory outputs");
endmodule : bst_tap

// ---- verilog/bst_defines.svh ----
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH
`define BST_IR_W        3
`define BST_IR_RESET    3'h1
`define BST_OP_DRIVE    3'h0
`define BST_OP_IDENT    3'h1
`define BST_OP_FLOAT    3'h2
`define BST_OP_SAMPLE   3'h4
`define BST_OP_BYPASS   3'h7
`define BST_ID_W        32
`define BST_CHAIN_LEN   129
`define BST_GATE_CELL   128
`define BST_GATE_RESET  1'h1
`define BST_OUT_CELLS   4
`endif

// ---- verilog/bst_pkg.sv ----
package bst_pkg;
  typedef enum logic [3:0] {
    BST_RESET      = 4'h0,
    BST_IDLE       = 4'h1,
    BST_SEL_DR     = 4'h2,
    BST_CAP_DR     = 4'h3,
    BST_SHIFT_DR   = 4'h4,
    BST_EXIT1_DR   = 4'h5,
    BST_PAUSE_DR   = 4'h6,
    BST_EXIT2_DR   = 4'h7,
    BST_UPD_DR     = 4'h8,
    BST_SEL_IR     = 4'h9,
    BST_CAP_IR     = 4'hA,
    BST_SHIFT_IR   = 4'hB,
    BST_EXIT1_IR   = 4'hC,
    BST_PAUSE_IR   = 4'hD,
    BST_EXIT2_IR   = 4'hE,
    BST_UPD_IR     = 4'hF
  } bst_state_t;
  // sampled scan pins, travel together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;
endpackage : bst_pkg

// ---- tb/bst_scan_master.sv ----
`timescale 1ns/1ps
module bst_scan_master
(
  output logic      TCK,
  output logic      TMS,
  output logic      TDI,
  input  wire logic TDO,
  input  wire logic TDO_OE_N
);
  // scan clock rests low between frames, mode select starts high
  initial
  begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end

  // one 64 ns scan period; data in toggles outside shift to expose leaks
  // an undriven data out has no pull, so it reads inverted here
  task step(input logic ms, input logic di, input logic sh,
            output logic dout);
    TMS = ms;
    TDI = sh ? di : ~TDI;
    #32;
    dout = TDO_OE_N ? ~TDO : TDO;
    TCK = 1'b1;
    #32;
    TCK = 1'b0;
  endtask : step
endmodule : bst_scan_master

// ---- tb/boundary_scan_test_port_bench.sv ----
`timescale 1ns/1ps
module boundary_scan_test_port_bench;
  import bst_pkg::*;
  localparam logic [31:0] ID = 32'h0C3A_5A61; // arbitrary identity value
  logic         clock = 1'b0;
  logic         reset_n = 1'b0;
  logic         tck, tms, tdi, tdo, tdo_oe_n, rd_en, term, test_mode;
  logic [128:0] ring = 129'h0;
  logic [3:0]   core = 4'h5;
  logic [3:0]   pin_out, pin_mid;
  logic         tm_mid;
  logic [128:0] v;
  int           error_cnt = 0;
  int           tests_run = 0;

  always #2 clock = ~clock;

  bst_tap #(.ID_VALUE(ID)) i_dut (.CLOCK(clock), .RESET_N(reset_n),
    .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
    .RING_IN(ring), .CORE_OUT(core), .PIN_OUT(pin_out),
    .READ_DATA_EN(rd_en), .INPUT_TERMINATION(term),
    .TEST_MODE(test_mode));
  bst_scan_master i_master (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .TDO_OE_N(tdo_oe_n));

  task chk(input logic [128:0] got, input logic [128:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // full ir or dr scan from idle back to idle
  task scan(input logic ir, input int n, input logic [128:0] din,
            output logic [128:0] dout);
    logic b;
    dout = '0;
    i_master.step(1'b1, 1'b0, 1'b0, b);
    if (ir)
      i_master.step(1'b1, 1'b0, 1'b0, b);
    i_master.step(1'b0, 1'b0, 1'b0, b);
    i_master.step(1'b0, 1'b0, 1'b0, b);
    chk(tdo_oe_n, 1'b0);
    pin_mid = pin_out;
    for (int i = 0; i < n; i++)
      i_master.step(i == n - 1, din[i], 1'b1, dout[i]);
    chk(pin_out, pin_mid);
    tm_mid = test_mode;
    i_master.step(1'b1, 1'b0, 1'b0, b);
    i_master.step(1'b0, 1'b0, 1'b0, b);
    chk(tdo_oe_n, 1'b1);
  endtask : scan

  // instruction load; only public codes are ever loaded
  // captured preset must shift out first
  task load(input logic [2:0] c);
    scan(1'b1, 3, {126'h0, c}, v);
    chk(v[2:0], 3'h1);
  endtask : load

  task t_ident;
    logic b;
    i_master.step(1'b0, 1'b0, 1'b0, b);
    load(3'h7);
    for (int i = 0; i < 3; i++)
      i_master.step(i > 0, 1'b0, 1'b0, b);
    for (int i = 0; i < 5; i++)
      i_master.step(1'b1, 1'b0, 1'b0, b);
    i_master.step(1'b0, 1'b0, 1'b0, b);
    scan(1'b0, 32, 129'h0, v);
    chk(v[31:0], ID);
    chk(v[0], 1'b1);
  endtask : t_ident

  task t_bypass;
    load(3'h7);
    scan(1'b0, 8, 129'hB5, v);
    chk(v[7:0], 8'h6A);
    chk(test_mode, 1'b0);
  endtask : t_bypass

  // ring capture for sample and float codes
  task t_ring(input logic [2:0] c, input logic en, input logic tm);
    load(c);
    chk({test_mode, term, rd_en}, {tm, ~tm, en});
    scan(1'b0, 129, 129'h0, v);
    chk(v, {1'b1, ring[127:0]});
    chk(pin_out, core);
  endtask : t_ring

  // start from a non-test code so the pending drive code is visible
  task t_drive;
    load(3'h7);
    load(3'h0);
    chk(tm_mid, 1'b0);
    chk({test_mode, term}, 2'b10);
    scan(1'b0, 129, 129'h0_0000_0000_0000_0000_0000_0000_0000_000A, v);
    chk(v, {1'b1, ring[127:0]});
    chk(pin_out, 4'hA);
    chk(rd_en, 1'b0);
    load(3'h1);
    chk({test_mode, term, rd_en, pin_out}, {3'b011, core});
  endtask : t_drive

  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    ring = 129'h0_1234_5678_9ABC_DEF0_0FED_CBA9_8765_4321;
    repeat (5) @(negedge clock);
    chk({tdo_oe_n, rd_en, term, test_mode}, 4'hE);
    chk(pin_out, core);
    t_ident();
    t_bypass();
    t_ring(3'h4, 1'b1, 1'b0);
    t_ring(3'h2, 1'b0, 1'b1);
    t_drive();
    close_out();
  end
endmodule : boundary_scan_test_port_bench
